// [shared/csm_map.svh]
// register offsets, field positions, reset values and widths of the shutter mask block
`ifndef CSM_MAP_SVH
`define CSM_MAP_SVH
`define CSM_ADDR_W 8
`define CSM_DATA_W 32
`define CSM_OFS_CMD 8'h70
`define CSM_OFS_MASK 8'h74
`define CSM_OFS_PULSES 8'h75
`define CSM_OFS_START 8'h76
`define CSM_OFS_TOGGLE 8'h77
`define CSM_OFS_FINE 8'h78
`define CSM_OFS_STATUS 8'h79
`define CSM_POS_W 13
`define CSM_FIELD_B_LSB 13
`define CSM_FLAG_BIT 26
`define CSM_CMD_IDLE 3'h0
`define CSM_CMD_ONCE 3'h1
`define CSM_CMD_FORCE_IDLE 3'h7
`define CSM_RST_PULSES 13'h0001
`define CSM_RST_POS 13'h0000
`define CSM_RST_FINE 13'h1FFF
`define CSM_INVALID_OFFSET 13'h0001
`endif

// [shared/csm_pkg.sv]
// types of the shutter mask block
package csm_pkg;
   typedef enum logic [1:0] {
      CSM_IDLE = 2'b00,
      CSM_ARMED = 2'b01,
      CSM_SKIP = 2'b10,
      CSM_MASK = 2'b11
   } csm_state_t;
   typedef logic [12:0] csm_pos_t;
endpackage

// [logic/csm_line_pulse.sv]
// one pulse window inside a line, set by two pixel toggle positions
`timescale 1ns/1ps
`include "csm_map.svh"
module csm_line_pulse (
   input wire logic mclk,
   input wire logic rst,
   input wire logic enable,
   input wire csm_pkg::csm_pos_t pixel_pos,
   input wire csm_pkg::csm_pos_t pos_a,
   input wire csm_pkg::csm_pos_t pos_b,
   output logic active
);
   import csm_pkg::*;
   logic next_active;
   always_comb begin
      // window is open from the first toggle to the second
      next_active = enable && (pixel_pos >= pos_a) && (pixel_pos < pos_b);
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         active <= 1'b0;
      end else begin
         active <= next_active;
      end
   end
endmodule // csm_line_pulse

// [logic/csm_shutter_mask.sv]
// substrate clear pulse generation and long exposure masking
`timescale 1ns/1ps
`include "csm_map.svh"
module csm_shutter_mask (
   input wire logic mclk,
   input wire logic rst,
   input wire logic reg_write,
   input wire logic [`CSM_ADDR_W-1:0] reg_addr,
   input wire logic [`CSM_DATA_W-1:0] reg_wdata,
   output logic [`CSM_DATA_W-1:0] reg_rdata,
   input wire logic field_sync,
   input wire logic line_start,
   input wire logic gate_line,
   input wire csm_pkg::csm_pos_t pixel_pos,
   input wire logic gate_pulse_in,
   output logic substrate_clear_pulse,
   output logic vertical_gate_transfer_pulse
);
   import csm_pkg::*;

   function automatic logic [12:0] fld(input logic [`CSM_DATA_W-1:0] d, input int lsb);
      fld = d[lsb +: 13];
   endfunction

   // programmed values
   logic [2:0] cmd, next_cmd;
   csm_pos_t exposure_field_count, next_exposure_field_count;
   csm_pos_t substrate_mask_field_count, next_substrate_mask_field_count;
   logic first_field_mask_bypass, next_first_field_mask_bypass;
   csm_pos_t substrate_pulses_per_field, next_substrate_pulses_per_field;
   logic gate_pulse_inhibit, next_gate_pulse_inhibit;
   csm_pos_t substrate_pulse_start_offset, next_substrate_pulse_start_offset;
   csm_pos_t substrate_toggle_pos_a, next_substrate_toggle_pos_a;
   csm_pos_t substrate_toggle_pos_b, next_substrate_toggle_pos_b;
   logic substrate_start_level, next_substrate_start_level;
   csm_pos_t fine_shutter_toggle_a, next_fine_shutter_toggle_a;
   csm_pos_t fine_shutter_toggle_b, next_fine_shutter_toggle_b;
   logic fine_update_at_field, next_fine_update_at_field;
   logic [`CSM_DATA_W-1:0] next_reg_rdata;
   logic cmd_write;

   // exposure sequencer
   csm_state_t state, next_state;
   logic [13:0] field_idx, next_field_idx;
   logic [13:0] mask_len;

   // line timing and working copies
   logic after_gate, next_after_gate;
   logic [12:0] lines_after, next_lines_after;
   logic [12:0] pulses_done, next_pulses_done;
   logic line_on, next_line_on;
   logic last_line, next_last_line;
   csm_pos_t act_offset, next_act_offset;
   csm_pos_t act_pulses, next_act_pulses;
   logic act_inhibit, next_act_inhibit;
   csm_pos_t act_tog_a, next_act_tog_a;
   csm_pos_t act_tog_b, next_act_tog_b;
   logic act_level, next_act_level;
   csm_pos_t act_fine_a, next_act_fine_a;
   csm_pos_t act_fine_b, next_act_fine_b;
   logic gate_mask, sub_mask;
   logic norm_active, fine_active, fine_en;
   logic next_substrate_clear_pulse, next_vertical_gate_transfer_pulse;
   logic [12:0] start_eff;

   always_comb begin
      next_cmd = cmd;
      next_exposure_field_count = exposure_field_count;
      next_substrate_mask_field_count = substrate_mask_field_count;
      next_first_field_mask_bypass = first_field_mask_bypass;
      next_substrate_pulses_per_field = substrate_pulses_per_field;
      next_gate_pulse_inhibit = gate_pulse_inhibit;
      next_substrate_pulse_start_offset = substrate_pulse_start_offset;
      next_substrate_toggle_pos_a = substrate_toggle_pos_a;
      next_substrate_toggle_pos_b = substrate_toggle_pos_b;
      next_substrate_start_level = substrate_start_level;
      next_fine_shutter_toggle_a = fine_shutter_toggle_a;
      next_fine_shutter_toggle_b = fine_shutter_toggle_b;
      next_fine_update_at_field = fine_update_at_field;
      cmd_write = 1'b0;
      if (reg_write) begin
         case (reg_addr)
            `CSM_OFS_CMD: begin
               next_cmd = reg_wdata[2:0];
               cmd_write = 1'b1;
            end
            `CSM_OFS_MASK: begin
               next_exposure_field_count = fld(reg_wdata, 0);
               next_substrate_mask_field_count = fld(reg_wdata, `CSM_FIELD_B_LSB);
               next_first_field_mask_bypass = reg_wdata[`CSM_FLAG_BIT];
            end
            `CSM_OFS_PULSES: begin
               next_substrate_pulses_per_field = fld(reg_wdata, 0);
               next_gate_pulse_inhibit = reg_wdata[`CSM_FLAG_BIT];
            end
            `CSM_OFS_START: begin
               next_substrate_pulse_start_offset = fld(reg_wdata, 0);
            end
            `CSM_OFS_TOGGLE: begin
               next_substrate_toggle_pos_a = fld(reg_wdata, 0);
               next_substrate_toggle_pos_b = fld(reg_wdata, `CSM_FIELD_B_LSB);
               next_substrate_start_level = reg_wdata[`CSM_FLAG_BIT];
            end
            `CSM_OFS_FINE: begin
               next_fine_shutter_toggle_a = fld(reg_wdata, 0);
               next_fine_shutter_toggle_b = fld(reg_wdata, `CSM_FIELD_B_LSB);
               next_fine_update_at_field = reg_wdata[`CSM_FLAG_BIT];
            end
            default: begin
            end
         endcase
      end
      case (reg_addr)
         `CSM_OFS_CMD: next_reg_rdata = {29'h0, cmd};
         `CSM_OFS_MASK: next_reg_rdata = {5'h0, first_field_mask_bypass, substrate_mask_field_count,
                                          exposure_field_count};
         `CSM_OFS_PULSES: next_reg_rdata = {5'h0, gate_pulse_inhibit, 13'h0, substrate_pulses_per_field};
         `CSM_OFS_START: next_reg_rdata = {19'h0, substrate_pulse_start_offset};
         `CSM_OFS_TOGGLE: next_reg_rdata = {5'h0, substrate_start_level, substrate_toggle_pos_b,
                                            substrate_toggle_pos_a};
         `CSM_OFS_FINE: next_reg_rdata = {5'h0, fine_update_at_field, fine_shutter_toggle_b,
                                          fine_shutter_toggle_a};
         `CSM_OFS_STATUS: next_reg_rdata = {16'h0, state, field_idx};
         default: next_reg_rdata = 32'h0000_0000;
      endcase
   end

   // only the main counter drives the masks; no secondary counter input exists
   always_comb begin
      mask_len = (exposure_field_count > substrate_mask_field_count) ? {1'b0, exposure_field_count}
                                                                       : {1'b0, substrate_mask_field_count};
      next_state = state;
      next_field_idx = field_idx;
      if (cmd_write && (next_cmd == `CSM_CMD_IDLE || next_cmd == `CSM_CMD_FORCE_IDLE)) begin
         next_state = CSM_IDLE;
      end else if (cmd_write) begin
         next_state = CSM_ARMED;
      end else if (field_sync) begin
         case (state)
            CSM_ARMED: begin
               next_field_idx = 14'h0000;
               if (first_field_mask_bypass) begin
                  next_state = CSM_SKIP;
               end else if (mask_len == 14'h0000) begin
                  next_state = CSM_IDLE;
               end else begin
                  next_state = CSM_MASK;
               end
            end
            CSM_SKIP: begin
               next_state = (mask_len == 14'h0000) ? CSM_IDLE : CSM_MASK;
            end
            CSM_MASK: begin
               next_field_idx = field_idx + 14'h0001;
               if (field_idx + 14'h0001 >= mask_len) begin
                  next_state = CSM_IDLE;
               end
            end
            default: next_state = CSM_IDLE;
         endcase
      end
   end

   // gate mask ends first when exposure_field_count is below substrate_mask_field_count, so gate pulses resume for readout
   assign gate_mask = (state == CSM_MASK) && (field_idx < {1'b0, exposure_field_count});
   assign sub_mask = (state == CSM_MASK) && (field_idx < {1'b0, substrate_mask_field_count});
   assign start_eff = (act_offset == 13'h0000) ? 13'h0001 : act_offset;
   // all-ones fine toggles switch the extra pulse off
   assign fine_en = last_line && !(act_fine_a == `CSM_RST_FINE && act_fine_b == `CSM_RST_FINE);

   always_comb begin
      next_after_gate = after_gate;
      next_lines_after = lines_after;
      next_pulses_done = pulses_done;
      next_line_on = line_on;
      next_last_line = last_line;
      next_act_offset = act_offset;
      next_act_pulses = act_pulses;
      next_act_inhibit = act_inhibit;
      next_act_tog_a = act_tog_a;
      next_act_tog_b = act_tog_b;
      next_act_level = act_level;
      next_act_fine_a = act_fine_a;
      next_act_fine_b = act_fine_b;
      if (field_sync) begin
         next_pulses_done = 13'h0000;
         next_lines_after = 13'h0000;
         next_line_on = 1'b0;
         next_last_line = 1'b0;
         if (fine_update_at_field) begin
            next_act_fine_a = fine_shutter_toggle_a;
            next_act_fine_b = fine_shutter_toggle_b;
         end
      end else if (line_start) begin
         next_after_gate = gate_line;
         next_line_on = 1'b0;
         next_last_line = 1'b0;
         if (after_gate) begin
            // working copies change here; with fine_update_at_field set the fine toggles change at field sync instead
            next_act_offset = substrate_pulse_start_offset;
            next_act_pulses = substrate_pulses_per_field;
            next_act_inhibit = gate_pulse_inhibit;
            next_act_tog_a = substrate_toggle_pos_a;
            next_act_tog_b = substrate_toggle_pos_b;
            next_act_level = substrate_start_level;
            if (!fine_update_at_field) begin
               next_act_fine_a = fine_shutter_toggle_a;
               next_act_fine_b = fine_shutter_toggle_b;
            end
            next_lines_after = 13'h0001;
         end else if (lines_after != 13'h0000 && lines_after != 13'h1FFF) begin
            next_lines_after = lines_after + 13'h0001;
         end
         // one pulse per line until the count is reached
         if (next_lines_after != 13'h0000 && next_lines_after >= ((after_gate && substrate_pulse_start_offset
             == 13'h0000) ? 13'h0001 : (after_gate ? substrate_pulse_start_offset : start_eff))
             && pulses_done < next_act_pulses) begin
            next_line_on = 1'b1;
            next_pulses_done = pulses_done + 13'h0001;
            next_last_line = (pulses_done + 13'h0001 == next_act_pulses);
         end
      end
   end

   csm_line_pulse u_norm (
      .mclk(mclk),
      .rst(rst),
      .enable(line_on),
      .pixel_pos(pixel_pos),
      .pos_a(act_tog_a),
      .pos_b(act_tog_b),
      .active(norm_active)
   );

   csm_line_pulse u_fine (
      .mclk(mclk),
      .rst(rst),
      .enable(fine_en),
      .pixel_pos(pixel_pos),
      .pos_a(act_fine_a),
      .pos_b(act_fine_b),
      .active(fine_active)
   );

   always_comb begin
      // masked substrate sits at its start level, i.e. inactive
      next_substrate_clear_pulse = sub_mask ? act_level : (act_level ^ (norm_active | fine_active));
      // inhibit hits only the gate path; substrate train keeps running
      next_vertical_gate_transfer_pulse = gate_pulse_in && !gate_mask && !act_inhibit;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cmd <= `CSM_CMD_IDLE;
         exposure_field_count <= `CSM_RST_POS;
         substrate_mask_field_count <= `CSM_RST_POS;
         first_field_mask_bypass <= 1'b0;
         substrate_pulses_per_field <= `CSM_RST_PULSES;
         gate_pulse_inhibit <= 1'b0;
         substrate_pulse_start_offset <= `CSM_RST_POS;
         substrate_toggle_pos_a <= `CSM_RST_POS;
         substrate_toggle_pos_b <= `CSM_RST_POS;
         substrate_start_level <= 1'b0;
         fine_shutter_toggle_a <= `CSM_RST_FINE;
         fine_shutter_toggle_b <= `CSM_RST_FINE;
         fine_update_at_field <= 1'b0;
         reg_rdata <= 32'h0000_0000;
         state <= CSM_IDLE;
         field_idx <= 14'h0000;
         after_gate <= 1'b0;
         lines_after <= 13'h0000;
         pulses_done <= 13'h0000;
         line_on <= 1'b0;
         last_line <= 1'b0;
         act_offset <= `CSM_RST_POS;
         act_pulses <= `CSM_RST_PULSES;
         act_inhibit <= 1'b0;
         act_tog_a <= `CSM_RST_POS;
         act_tog_b <= `CSM_RST_POS;
         act_level <= 1'b0;
         act_fine_a <= `CSM_RST_FINE;
         act_fine_b <= `CSM_RST_FINE;
         substrate_clear_pulse <= 1'b0;
         vertical_gate_transfer_pulse <= 1'b0;
      end else begin
         cmd <= next_cmd;
         exposure_field_count <= next_exposure_field_count;
         substrate_mask_field_count <= next_substrate_mask_field_count;
         first_field_mask_bypass <= next_first_field_mask_bypass;
         substrate_pulses_per_field <= next_substrate_pulses_per_field;
         gate_pulse_inhibit <= next_gate_pulse_inhibit;
         substrate_pulse_start_offset <= next_substrate_pulse_start_offset;
         substrate_toggle_pos_a <= next_substrate_toggle_pos_a;
         substrate_toggle_pos_b <= next_substrate_toggle_pos_b;
         substrate_start_level <= next_substrate_start_level;
         fine_shutter_toggle_a <= next_fine_shutter_toggle_a;
         fine_shutter_toggle_b <= next_fine_shutter_toggle_b;
         fine_update_at_field <= next_fine_update_at_field;
         reg_rdata <= next_reg_rdata;
         state <= next_state;
         field_idx <= next_field_idx;
         after_gate <= next_after_gate;
         lines_after <= next_lines_after;
         pulses_done <= next_pulses_done;
         line_on <= next_line_on;
         last_line <= next_last_line;
         act_offset <= next_act_offset;
         act_pulses <= next_act_pulses;
         act_inhibit <= next_act_inhibit;
         act_tog_a <= next_act_tog_a;
         act_tog_b <= next_act_tog_b;
         act_level <= next_act_level;
         act_fine_a <= next_act_fine_a;
         act_fine_b <= next_act_fine_b;
         substrate_clear_pulse <= next_substrate_clear_pulse;
         vertical_gate_transfer_pulse <= next_vertical_gate_transfer_pulse;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_once_cmd;
      reg_write && reg_addr == `CSM_OFS_CMD && reg_wdata[2:0] == `CSM_CMD_ONCE;
   endsequence
   sequence s_armed_sync;
      state == CSM_ARMED && field_sync && !reg_write;
   endsequence

   a_cmd_arms: assert property (s_once_cmd |=> state == CSM_ARMED)
      else $error("activation did not arm the sequencer");
   a_bypass_skip: assert property (s_armed_sync ##0 first_field_mask_bypass |=> state == CSM_SKIP)
      else $error("bypass did not skip the first field");
   a_next_field_mask: assert property (s_armed_sync ##0 !first_field_mask_bypass ##0 mask_len != 14'h0000
      |=> state == CSM_MASK && field_idx == 14'h0000)
      else $error("mask not applied from next field");
   a_zero_counts: assert property (s_armed_sync ##0 mask_len == 14'h0000 ##0 !first_field_mask_bypass
      |=> state == CSM_IDLE)
      else $error("zero counts still masked");
   a_gate_masked: assert property (gate_mask |=> !vertical_gate_transfer_pulse)
      else $error("gate pulse leaked during exposure");
   a_sub_masked: assert property (sub_mask |=> substrate_clear_pulse == $past(act_level))
      else $error("substrate not held inactive under mask");
   a_inhibit_gate: assert property (act_inhibit |=> !vertical_gate_transfer_pulse)
      else $error("inhibit did not stop gate pulse");
   a_pulse_limit: assert property (pulses_done <= act_pulses || $past(field_sync) || $past(line_start))
      else $error("too many substrate pulses in field");
   a_idle_unmasked: assert property (state == CSM_IDLE
      |=> vertical_gate_transfer_pulse == ($past(gate_pulse_in) && !$past(act_inhibit)))
      else $error("gate pulse not passed while idle");
   a_latch_line: assert property (line_start && after_gate && !field_sync
      |=> act_pulses == $past(substrate_pulses_per_field))
      else $error("working copy not updated after gate line");
endmodule // csm_shutter_mask

// [test/csm_far_model.sv]
// far side model: line and field timing source plus pulse counter of the vertical driver
`timescale 1ns/1ps
module csm_far_model #(
   parameter int LINE_LEN = 16,
   parameter int FIELD_LINES = 12,
   parameter int GATE_LINE = 2
) (
   input wire logic mclk,
   input wire logic rst,
   output csm_pkg::csm_pos_t pixel_pos,
   output logic line_start,
   output logic field_sync,
   output logic gate_line,
   output logic gate_pulse_in,
   input wire logic substrate_clear_pulse,
   input wire logic vertical_gate_transfer_pulse,
   output logic field_done,
   output int sub_rises,
   output int gate_rises,
   output int first_line
);
   import csm_pkg::*;
   int pix = LINE_LEN - 1;
   int line = FIELD_LINES - 1;
   int sub_n = 0;
   int gate_n = 0;
   int first_n = -1;
   logic sub_q = 1'b0;
   logic gate_q = 1'b0;
   initial begin
      {pixel_pos, line_start, field_sync, gate_line, gate_pulse_in, field_done} = '0;
      {sub_rises, gate_rises, first_line} = '0;
   end
   // driven on the falling edge, clear of the block's sampling edge
   always @(negedge mclk) begin
      if (rst) begin
         pix = LINE_LEN - 1;
         line = FIELD_LINES - 1;
      end else begin
         pix = (pix + 1) % LINE_LEN;
         if (pix == 0) begin
            line = (line + 1) % FIELD_LINES;
         end
         // rising edges count pulses whatever the start level
         if (substrate_clear_pulse && !sub_q) begin
            sub_n++;
            if (first_n < 0) begin
               first_n = line;
            end
         end
         if (vertical_gate_transfer_pulse && !gate_q) begin
            gate_n++;
         end
         if (pix == 0 && line == 0) begin
            sub_rises <= sub_n;
            gate_rises <= gate_n;
            first_line <= first_n;
            sub_n = 0;
            gate_n = 0;
            first_n = -1;
         end
      end
      sub_q = substrate_clear_pulse;
      gate_q = vertical_gate_transfer_pulse;
      pixel_pos <= pix[12:0];
      line_start <= !rst && pix == 0;
      field_sync <= !rst && pix == 0 && line == 0;
      // one assignment per edge; counts above are already latched
      field_done <= !rst && pix == 0 && line == 0;
      gate_line <= !rst && line == GATE_LINE;
      gate_pulse_in <= !rst && line == GATE_LINE && pix >= 4 && pix < 8;
   end
endmodule // csm_far_model

// [test/csm_shutter_mask_tb_top.sv]
// testbench of the shutter mask block
`timescale 1ns/1ps
`include "csm_map.svh"
module csm_shutter_mask_tb_top;
   import csm_pkg::*;
   localparam int GL = 2;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic reg_write = 1'b0;
   logic [`CSM_ADDR_W-1:0] reg_addr = 8'h00;
   logic [`CSM_DATA_W-1:0] reg_wdata = 32'h00000000;
   logic [`CSM_DATA_W-1:0] reg_rdata;
   logic field_sync, line_start, gate_line, gate_pulse_in, field_done;
   logic substrate_clear_pulse, vertical_gate_transfer_pulse;
   csm_pos_t pixel_pos;
   int sub_rises, gate_rises, first_line;
   int err_count = 0;
   int checks = 0;
   int offs[3] = '{0, 2, 5};
   always #5 mclk = ~mclk;
   csm_shutter_mask csm_shutter_mask_inst (.mclk(mclk), .rst(rst), .reg_write(reg_write), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .field_sync(field_sync), .line_start(line_start),
      .gate_line(gate_line), .pixel_pos(pixel_pos), .gate_pulse_in(gate_pulse_in),
      .substrate_clear_pulse(substrate_clear_pulse), .vertical_gate_transfer_pulse(vertical_gate_transfer_pulse));
   csm_far_model #(.GATE_LINE(GL)) csm_far_model_inst (.mclk(mclk), .rst(rst), .pixel_pos(pixel_pos),
      .line_start(line_start), .field_sync(field_sync), .gate_line(gate_line), .gate_pulse_in(gate_pulse_in),
      .substrate_clear_pulse(substrate_clear_pulse), .vertical_gate_transfer_pulse(vertical_gate_transfer_pulse),
      .field_done(field_done), .sub_rises(sub_rises), .gate_rises(gate_rises), .first_line(first_line));
   task automatic stop_test;
      if (err_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge mclk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(negedge mclk);
      reg_write <= 1'b0;
   endtask
   // registered read data: address settles for two edges before the look
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      @(negedge mclk);
      reg_addr <= a;
      @(posedge mclk);
      @(posedge mclk);
      #1;
      checks++;
      if ((reg_rdata & m) !== exp) begin
         err_count++;
         $display("[ERR] %0t read %h got %h exp %h", $time, a, reg_rdata & m, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      checks++;
      if (got != exp) begin
         err_count++;
         $display("[ERR] %0t count got %0d exp %0d", $time, got, exp);
      end
   endtask
   task automatic wait_field;
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (field_done !== 1'b1 && n < 400);
      if (n >= 400) begin
         err_count++;
         $display("[ERR] %0t no field boundary", $time);
         stop_test();
      end
   endtask
   task automatic field_chk(input int s, input int g);
      wait_field();
      chk_cnt(sub_rises, s);
      chk_cnt(gate_rises, g);
   endtask
   // new settings land at the line after the gate line, so skip one whole field
   task automatic settle;
      wait_field();
      wait_field();
   endtask
   initial begin
      repeat (16) @(negedge mclk);
      rst <= 1'b0;
      rd_chk(`CSM_OFS_PULSES, 32'h00000001, 32'h07FFFFFF);
      rd_chk(`CSM_OFS_FINE, 32'h03FFFFFF, 32'h07FFFFFF);
      rd_chk(`CSM_OFS_MASK, 32'h00000000, 32'h04000000);
      rd_chk(`CSM_OFS_STATUS, 32'h00000000, 32'h0000C000);
      wr(8'h7F, 32'hFFFFFFFF);
      rd_chk(8'h7F, 32'h00000000, 32'hFFFFFFFF);
      wr(`CSM_OFS_PULSES, 32'h00000003);
      for (int i = 0; i < 2; i++) begin
         wr(`CSM_OFS_TOGGLE, {5'h00, i[0], 13'h0006, 13'h0002});
         settle();
         field_chk(3, 1);
         chk_cnt(first_line, GL + 1);
      end
      foreach (offs[k]) begin
         wr(`CSM_OFS_START, {19'h00000, offs[k][12:0]});
         settle();
         field_chk(3, 1);
         chk_cnt(first_line, GL + (offs[k] == 0 ? 1 : offs[k]));
      end
      wr(`CSM_OFS_START, 32'h00000000);
      for (int i = 0; i < 2; i++) begin
         wr(`CSM_OFS_FINE, {5'h00, i[0], 13'h000C, 13'h000A});
         settle();
         field_chk(4, 1);
      end
      wr(`CSM_OFS_FINE, 32'h03FFFFFF);
      settle();
      field_chk(3, 1);
      wr(`CSM_OFS_PULSES, 32'h04000003);
      settle();
      field_chk(3, 0);
      wr(`CSM_OFS_PULSES, 32'h00000003);
      wr(`CSM_OFS_MASK, 32'h00000000);
      settle();
      wr(`CSM_OFS_CMD, 32'h00000001);
      for (int f = 0; f < 3; f++) begin
         field_chk(3, 1);
      end
      // three mask fields, two of them also block the gate pulse
      for (int b = 0; b < 2; b++) begin
         wr(`CSM_OFS_MASK, {5'h00, b[0], 13'h0003, 13'h0002});
         rd_chk(`CSM_OFS_MASK, {5'h00, b[0], 13'h0003, 13'h0002}, 32'h07FFFFFF);
         wait_field();
         wr(`CSM_OFS_CMD, 32'h00000001);
         rd_chk(`CSM_OFS_STATUS, 32'h00004000, 32'h0000C000);
         wait_field();
         for (int f = 0; f < 6; f++) begin
            field_chk((f >= b && f < b + 3) ? 0 : 3, (f >= b && f < b + 2) ? 0 : 1);
         end
         rd_chk(`CSM_OFS_STATUS, 32'h00000000, 32'h0000C000);
      end
      // force idle must drop an armed sequencer before its first field
      wr(`CSM_OFS_CMD, 32'h00000001);
      wr(`CSM_OFS_CMD, 32'h00000007);
      rd_chk(`CSM_OFS_STATUS, 32'h00000000, 32'h0000C000);
      stop_test();
   end
endmodule // csm_shutter_mask_tb_top
